// ### core/pulse_cmd_regs.vh
// Overview of operation
// (RQ1) Decode eight-valued input mode: switch, dual-pulse, step-direction, quadrature.
// (RQ2) Step-direction: count step pulses forward or reverse by direction level.
// (RQ3) Dual-pulse: forward input counts up one, reverse input counts down one.
// (RQ4) Quadrature: reverse lagging forward counts up, leading counts down.
// (RQ5) Quadrature multiplication one, two or four counts per cycle.
// (RQ6) Mode zero: switch on gives step-direction negative, off dual-pulse negative.
// (RQ7) Switch and parameters sampled only at power-up.
// (RQ8) Resolution equals 1000 times numerator over denominator, 100 to 100000.
// (RQ9) Resolution out of range raises gear-setting warning.
// (RQ10) Power reapplied with gear warning active escalates to gear alarm.
// (RQ11) Forward raises position, reverse lowers it; direction bit picks shaft sense.
// (RQ12) After position-loss alarm reset, setting 0 blocks until request rising edge.
// (RQ13) Servo-on inactive holds deviation at zero and discards pulses.
// (RQ14) Gear numerator and denominator accept 1 to 1000.
// (RQ15) Inputs synchronised before edge detection, polarity applied before decoding.
`ifndef PULSE_CMD_REGS_VH
`define PULSE_CMD_REGS_VH

// ==========================================================
// Input mode codes
`define MODE_SWITCH        3'h0
`define MODE_DUAL_NEG      3'h1
`define MODE_DUAL_POS      3'h2
`define MODE_STEP_NEG      3'h3
`define MODE_STEP_POS      3'h4
`define MODE_QUAD_X1       3'h5
`define MODE_QUAD_X2       3'h6
`define MODE_QUAD_X4       3'h7

// ==========================================================
// Gear and resolution limits
`define GEAR_MIN           10'h001
`define GEAR_MAX           10'h3E8
`define RES_BASE           17'h003E8
`define RES_MIN_MULT       5'h0A
`define RES_MAX_MULT       7'h64
`define RES_DEFAULT        17'h003E8

// ==========================================================
// Widths, division steps and settle cycles
`define POS_W              32
`define RES_W              17
`define DIV_STEPS          5'h14
`define SETTLE_CYCLES      3'h7

`endif

// ### core/pin_sync3.v
`timescale 1ns/1ps
module pin_sync3 #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Pins and settled levels
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level_r
);

// ==========================================================
// Three-stage chain, settle when stages two and three agree
reg [WIDTH-1:0] s1_r;
reg [WIDTH-1:0] s2_r;
reg [WIDTH-1:0] s3_r;
integer i;

always @(posedge clock) begin
    if (!rst_n) begin
        s1_r    <= {WIDTH{1'b0}};
        s2_r    <= {WIDTH{1'b0}};
        s3_r    <= {WIDTH{1'b0}};
        level_r <= {WIDTH{1'b0}};
    end else begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        for (i = 0; i < WIDTH; i = i + 1) begin
            // Filters single-cycle glitch on stage two
            if (s2_r[i] == s3_r[i])
                level_r[i] <= s3_r[i];
        end
    end
end

endmodule // pin_sync3

// ### core/pulse_command_position_input.v
`timescale 1ns/1ps
`include "pulse_cmd_regs.vh"
module pulse_command_position_input #(
    parameter POS_W = `POS_W
) (
    // Clock and reset (reset stands for power-up)
    input  wire                  clock,
    input  wire                  rst_n,
    // Command pulse pins from controller
    input  wire                  step_pulse_in,
    input  wire                  direction_in,
    input  wire                  forward_pulse_in,
    input  wire                  reverse_pulse_in,
    input  wire                  position_request_in,
    // Switch and system parameters, sampled at power-up
    input  wire                  input_mode_switch,
    input  wire [2:0]            pulse_input_mode,
    input  wire [9:0]            gear_denominator,
    input  wire [9:0]            gear_numerator,
    input  wire                  positive_is_clockwise,
    input  wire                  loss_release_immediate,
    // Power cycle of supplies while logic stays clocked
    input  wire                  power_reapplied,
    // Servo state from same-clock logic
    input  wire                  servo_on,
    input  wire                  abs_loss_alarm,
    input  wire                  feedback_up,
    input  wire                  feedback_down,
    // Command results
    output reg  [POS_W-1:0]      command_position_r,
    output reg  [POS_W-1:0]      deviation_r,
    output reg                   motor_step_cw_r,
    output reg                   motor_step_ccw_r,
    output reg                   command_up_r,
    output reg                   command_down_r,
    // Configuration status
    output reg  [2:0]            active_mode_r,
    output reg  [`RES_W-1:0]     resolution_ppr_r,
    output reg                   resolution_valid_r,
    output reg                   gear_warning_r,
    output reg                   gear_alarm_r,
    output reg                   pulse_blocked_r
);

// ==========================================================
// Pin synchroniser
wire [4:0] pin_level;

pin_sync3 #(
    .WIDTH   (5)
) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin_in  ({position_request_in, reverse_pulse_in, forward_pulse_in,
               direction_in, step_pulse_in}),
    .level_r (pin_level)
); // RQ15

// ==========================================================
// Power-up latch of switch and parameters
reg        latched_r;
reg [9:0]  den_r;
reg [9:0]  num_r;
reg        cw_pos_r;
reg        release_imm_r;
reg        gear_bad_r;

function gear_ok;
    input [9:0] den;
    input [9:0] num;
    begin
        gear_ok = (den >= `GEAR_MIN) && (den <= `GEAR_MAX)
               && (num >= `GEAR_MIN) && (num <= `GEAR_MAX); // RQ14
    end
endfunction

// Range check without division: A <= 10*B and B <= 100*A
function res_in_range;
    input [9:0] den;
    input [9:0] num;
    reg   [16:0] ten_num;
    reg   [16:0] hund_den;
    begin
        ten_num      = {7'h00, num} * 17'h0000A;
        hund_den     = {7'h00, den} * 17'h00064;
        res_in_range = ({7'h00, den} <= ten_num)
                    && ({7'h00, num} <= hund_den); // RQ8
    end
endfunction

function [2:0] resolve_mode;
    input [2:0] mode;
    input       sw;
    begin
        if (mode == `MODE_SWITCH)
            resolve_mode = sw ? `MODE_STEP_NEG : `MODE_DUAL_NEG; // RQ6
        else
            resolve_mode = mode; // RQ1
    end
endfunction

wire sample_now = !latched_r || power_reapplied;

always @(posedge clock) begin
    if (!rst_n) begin
        latched_r     <= 1'b0;
        active_mode_r <= `MODE_DUAL_NEG;
        den_r         <= `GEAR_MIN;
        num_r         <= `GEAR_MIN;
        cw_pos_r      <= 1'b1;
        release_imm_r <= 1'b0;
        gear_bad_r    <= 1'b0;
    end else if (sample_now) begin // RQ7
        latched_r     <= 1'b1;
        active_mode_r <= resolve_mode(pulse_input_mode, input_mode_switch);
        den_r         <= gear_denominator;
        num_r         <= gear_numerator;
        cw_pos_r      <= positive_is_clockwise;
        release_imm_r <= loss_release_immediate;
        gear_bad_r    <= !gear_ok(gear_denominator, gear_numerator)
                      || !res_in_range(gear_denominator, gear_numerator);
    end
end

// ==========================================================
// Gear warning and alarm
reg latch_seen_r;

always @(posedge clock) begin
    if (!rst_n) begin
        latch_seen_r   <= 1'b0;
        gear_warning_r <= 1'b0;
        gear_alarm_r   <= 1'b0;
    end else begin
        latch_seen_r <= latched_r;
        if (latched_r && latch_seen_r)
            gear_warning_r <= gear_bad_r; // RQ9
        // Warning still set when supplies return escalates
        if (power_reapplied && latched_r && gear_warning_r)
            gear_alarm_r <= 1'b1; // RQ10
    end
end

// ==========================================================
// Resolution by restoring division, runs after each latch
reg [19:0] dividend_r;
reg [19:0] quotient_r;
reg [19:0] remainder_r;
reg [4:0]  div_cnt_r;
reg        div_busy_r;
wire [20:0] rem_shift = {remainder_r, dividend_r[19]};
wire [20:0] rem_sub   = rem_shift - {11'h000, den_r};

always @(posedge clock) begin
    if (!rst_n) begin
        dividend_r         <= 20'h00000;
        quotient_r         <= 20'h00000;
        remainder_r        <= 20'h00000;
        div_cnt_r          <= 5'h00;
        div_busy_r         <= 1'b0;
        resolution_ppr_r   <= `RES_DEFAULT;
        resolution_valid_r <= 1'b0;
    end else if (sample_now) begin
        div_busy_r         <= 1'b0;
        resolution_valid_r <= 1'b0;
    end else if (!div_busy_r && !resolution_valid_r) begin
        // 1000 * numerator fits in twenty bits
        dividend_r  <= {10'h000, num_r} * 20'h003E8;
        quotient_r  <= 20'h00000;
        remainder_r <= 20'h00000;
        div_cnt_r   <= `DIV_STEPS;
        div_busy_r  <= (den_r != 10'h000);
    end else if (div_busy_r) begin
        dividend_r <= {dividend_r[18:0], 1'b0};
        if (!rem_sub[20]) begin
            remainder_r <= rem_sub[19:0];
            quotient_r  <= {quotient_r[18:0], 1'b1};
        end else begin
            remainder_r <= rem_shift[19:0];
            quotient_r  <= {quotient_r[18:0], 1'b0};
        end
        div_cnt_r <= div_cnt_r - 5'h01;
        if (div_cnt_r == 5'h01) begin
            div_busy_r         <= 1'b0;
            resolution_valid_r <= 1'b1;
        end
    end else if (resolution_valid_r && !div_busy_r && div_cnt_r == 5'h00) begin
        resolution_ppr_r <= quotient_r[`RES_W-1:0]; // RQ8
        div_cnt_r        <= 5'h1F;
    end
end

// ==========================================================
// Polarity and edge detection
wire is_neg  = (active_mode_r == `MODE_DUAL_NEG) || (active_mode_r == `MODE_STEP_NEG);
wire is_step = (active_mode_r == `MODE_STEP_NEG) || (active_mode_r == `MODE_STEP_POS);
wire is_dual = (active_mode_r == `MODE_DUAL_NEG) || (active_mode_r == `MODE_DUAL_POS);
wire is_quad = (active_mode_r >= `MODE_QUAD_X1);

// Negative logic means active while the line is low; quadrature has no polarity
wire [3:0] pol_level = (is_neg ? ~pin_level[3:0] : pin_level[3:0]); // RQ15
reg  [3:0] prev_r;
reg        req_prev_r;

always @(posedge clock) begin
    if (!rst_n) begin
        prev_r     <= 4'h0;
        req_prev_r <= 1'b0;
    end else begin
        prev_r     <= pol_level;
        req_prev_r <= pin_level[4];
    end
end

wire step_act  = pol_level[0] & ~prev_r[0];
wire dir_fwd   = pol_level[1];
wire fwd_act   = pol_level[2] & ~prev_r[2];
wire rev_act   = pol_level[3] & ~prev_r[3];
wire a_now     = pol_level[2];
wire b_now     = pol_level[3];
wire a_rise    = a_now & ~prev_r[2];
wire a_fall    = ~a_now & prev_r[2];
wire b_rise    = b_now & ~prev_r[3];
wire b_fall    = ~b_now & prev_r[3];
wire req_rise  = pin_level[4] & ~req_prev_r;

// ==========================================================
// Decoder
reg up_nxt;
reg dn_nxt;

always @* begin
    up_nxt = 1'b0;
    dn_nxt = 1'b0;
    if (is_step) begin
        up_nxt = step_act & dir_fwd; // RQ2
        dn_nxt = step_act & ~dir_fwd; // RQ2
    end else if (is_dual) begin
        // Both at once cancel out
        up_nxt = fwd_act & ~rev_act; // RQ3
        dn_nxt = rev_act & ~fwd_act; // RQ3
    end else if (is_quad) begin
        case (active_mode_r)
            `MODE_QUAD_X1: begin
                up_nxt = a_rise & ~b_now; // RQ5
                dn_nxt = a_fall & ~b_now; // RQ5
            end
            `MODE_QUAD_X2: begin
                up_nxt = (a_rise & ~b_now) | (a_fall & b_now); // RQ5
                dn_nxt = (a_rise & b_now) | (a_fall & ~b_now); // RQ5
            end
            `MODE_QUAD_X4: begin
                // Reverse phase lagging gives forward counts
                up_nxt = (a_rise & ~b_now) | (a_fall & b_now)
                       | (b_rise & a_now) | (b_fall & ~a_now); // RQ4
                dn_nxt = (a_rise & b_now) | (a_fall & ~b_now)
                       | (b_rise & ~a_now) | (b_fall & a_now); // RQ4
            end
            default: begin
                up_nxt = 1'b0;
                dn_nxt = 1'b0;
            end
        endcase
    end
end

// ==========================================================
// Position-loss release gate
reg alarm_prev_r;

always @(posedge clock) begin
    if (!rst_n) begin
        alarm_prev_r    <= 1'b0;
        pulse_blocked_r <= 1'b0;
    end else begin
        alarm_prev_r <= abs_loss_alarm;
        if (abs_loss_alarm)
            pulse_blocked_r <= 1'b1;
        else if (alarm_prev_r)
            pulse_blocked_r <= !release_imm_r; // RQ12
        else if (req_rise)
            pulse_blocked_r <= 1'b0; // RQ12
    end
end

// ==========================================================
// Command position, deviation and shaft direction
// Pins and polarity refill after a latch; earlier edges are false ones
reg [2:0] settle_r;
always @(posedge clock) begin
    if (!rst_n || sample_now)
        settle_r <= 3'h0;
    else if (settle_r != `SETTLE_CYCLES)
        settle_r <= settle_r + 3'h1;
end
wire accept = (settle_r == `SETTLE_CYCLES) && servo_on && !pulse_blocked_r && !gear_alarm_r;
wire cmd_up = accept & up_nxt & ~dn_nxt;
wire cmd_dn = accept & dn_nxt & ~up_nxt; // RQ13

function [POS_W-1:0] step_value;
    input [POS_W-1:0] val;
    input             inc;
    input             dec;
    begin
        if (inc && !dec)
            step_value = val + {{(POS_W-1){1'b0}}, 1'b1};
        else if (dec && !inc)
            step_value = val - {{(POS_W-1){1'b0}}, 1'b1};
        else
            step_value = val;
    end
endfunction

always @(posedge clock) begin
    if (!rst_n) begin
        command_position_r <= {POS_W{1'b0}};
        deviation_r        <= {POS_W{1'b0}};
        command_up_r       <= 1'b0;
        command_down_r     <= 1'b0;
        motor_step_cw_r    <= 1'b0;
        motor_step_ccw_r   <= 1'b0;
    end else begin
        command_position_r <= step_value(command_position_r, cmd_up, cmd_dn); // RQ11
        if (!servo_on)
            deviation_r <= {POS_W{1'b0}}; // RQ13
        else
            deviation_r <= step_value(step_value(deviation_r, cmd_up, cmd_dn),
                                      feedback_down, feedback_up);
        command_up_r     <= cmd_up;
        command_down_r   <= cmd_dn;
        motor_step_cw_r  <= cw_pos_r ? cmd_up : cmd_dn; // RQ11
        motor_step_ccw_r <= cw_pos_r ? cmd_dn : cmd_up; // RQ11
    end
end

endmodule // pulse_command_position_input

// ### testbench/pulse_command_position_input_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module pcpi_sva #(
    parameter POS_W = 32
) (
    input wire             clock,
    input wire             rst_n,
    input wire             power_reapplied,
    input wire [2:0]       pulse_input_mode,
    input wire             input_mode_switch,
    input wire             servo_on,
    input wire             abs_loss_alarm,
    input wire [POS_W-1:0] command_position_r,
    input wire [POS_W-1:0] deviation_r,
    input wire             command_up_r,
    input wire             command_down_r,
    input wire [2:0]       active_mode_r,
    input wire             gear_warning_r,
    input wire             gear_alarm_r,
    input wire             pulse_blocked_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_mode_nonzero: assert property (active_mode_r != 3'h0)
        else $error("resolved mode is zero");
    a_mode_taken: assert property ((power_reapplied || !$past(rst_n)) && pulse_input_mode != 3'h0
        |=> active_mode_r == $past(pulse_input_mode)) else $error("mode not latched");
    a_switch_select: assert property ((power_reapplied || !$past(rst_n)) && pulse_input_mode == 3'h0
        |=> active_mode_r == ($past(input_mode_switch) ? 3'h3 : 3'h1))
        else $error("switch mode wrong");
    a_alarm_raise: assert property (power_reapplied && gear_warning_r
        |=> gear_alarm_r) else $error("gear alarm missing");
    a_alarm_stays: assert property (gear_alarm_r |=> gear_alarm_r)
        else $error("gear alarm dropped");
    a_up_count: assert property (command_up_r |-> !command_down_r
        && command_position_r == $past(command_position_r) + 1) else $error("up count");
    a_down_count: assert property (command_down_r |-> !command_up_r
        && command_position_r == $past(command_position_r) - 1) else $error("down count");
    a_servo_clear: assert property (!servo_on |=> deviation_r == '0)
        else $error("deviation not cleared");
    a_loss_block: assert property (abs_loss_alarm |=> pulse_blocked_r)
        else $error("pulses not blocked");
endmodule // pcpi_sva

bind pulse_command_position_input pcpi_sva #(.POS_W(POS_W)) u_sva (
    .clock(clock), .rst_n(rst_n), .power_reapplied(power_reapplied),
    .pulse_input_mode(pulse_input_mode), .input_mode_switch(input_mode_switch),
    .servo_on(servo_on), .abs_loss_alarm(abs_loss_alarm),
    .command_position_r(command_position_r), .deviation_r(deviation_r),
    .command_up_r(command_up_r), .command_down_r(command_down_r),
    .active_mode_r(active_mode_r), .gear_warning_r(gear_warning_r),
    .gear_alarm_r(gear_alarm_r), .pulse_blocked_r(pulse_blocked_r));

// ### testbench/pulse_osc_model.sv
`timescale 1ns/1ps
// ==========================================
// Pulse oscillator on the controller side
module pulse_osc_model (
    input  wire  clock,
    output logic step_pulse_in    = 1'b0,
    output logic direction_in     = 1'b0,
    output logic forward_pulse_in = 1'b0,
    output logic reverse_pulse_in = 1'b0
);
    // Initialisers, not an initial block, so idle() at time zero wins
    // Six cycles per level, twice the input filter
    task automatic gap();
        repeat (6) @(negedge clock);
    endtask
    // Inactive idle so no stray edge gets counted
    task automatic idle(input bit pos);
        {step_pulse_in, forward_pulse_in, reverse_pulse_in} = pos ? 3'h0 : 3'h7;
        gap();
    endtask
    // Kind 0 dual, 1 step, 2 quadrature
    task automatic send(input int kind, input bit pos, input bit fwd, input int n);
        logic [7:0] q;
        q = fwd ? 8'h78 : 8'hB4;
        direction_in = fwd ? pos : !pos;
        gap();
        for (int i = 0; i < n; i++) begin
            for (int j = 0; j < 2; j++) begin
                if (kind == 0 && fwd) forward_pulse_in = pos ^ j[0];
                if (kind == 0 && !fwd) reverse_pulse_in = pos ^ j[0];
                if (kind == 1) step_pulse_in = pos ^ j[0];
                if (kind == 2) {reverse_pulse_in, forward_pulse_in} = q[7-4*j -: 2];
                gap();
                if (kind == 2) {reverse_pulse_in, forward_pulse_in} = q[5-4*j -: 2];
                if (kind == 2) gap();
            end
        end
    endtask
endmodule // pulse_osc_model

// ### testbench/pulse_command_position_input_tb_top.sv
`timescale 1ns/1ps
module pulse_command_position_input_tb_top;
    // ==========================================
    // Stimulus and observation
    logic        clock = 1'b0, rst_n = 1'b0, position_request_in = 1'b0;
    logic        input_mode_switch = 1'b0, power_reapplied = 1'b0, servo_on = 1'b1;
    logic        abs_loss_alarm = 1'b0, feedback_up = 1'b0, feedback_down = 1'b0;
    logic        positive_is_clockwise = 1'b1, loss_release_immediate = 1'b0;
    logic [2:0]  pulse_input_mode = 3'h2;
    logic [9:0]  gear_denominator = 10'h001, gear_numerator = 10'h001;
    wire         step_pulse_in, direction_in, forward_pulse_in, reverse_pulse_in;
    wire  [31:0] command_position_r, deviation_r;
    wire         motor_step_cw_r, motor_step_ccw_r, command_up_r, command_down_r;
    wire  [2:0]  active_mode_r;
    wire  [16:0] resolution_ppr_r;
    wire         resolution_valid_r, gear_warning_r, gear_alarm_r, pulse_blocked_r;
    int          err_count = 0, n_checks = 0, cw_n = 0, ccw_n = 0;
    logic [31:0] p0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cw_n <= cw_n + (motor_step_cw_r === 1'b1);
        ccw_n <= ccw_n + (motor_step_ccw_r === 1'b1);
    end
    pulse_osc_model u_osc (.clock(clock), .step_pulse_in(step_pulse_in),
        .direction_in(direction_in), .forward_pulse_in(forward_pulse_in),
        .reverse_pulse_in(reverse_pulse_in));
    pulse_command_position_input dut (.clock(clock), .rst_n(rst_n),
        .step_pulse_in(step_pulse_in), .direction_in(direction_in),
        .forward_pulse_in(forward_pulse_in), .reverse_pulse_in(reverse_pulse_in),
        .position_request_in(position_request_in), .input_mode_switch(input_mode_switch),
        .pulse_input_mode(pulse_input_mode), .gear_denominator(gear_denominator),
        .gear_numerator(gear_numerator), .positive_is_clockwise(positive_is_clockwise),
        .loss_release_immediate(loss_release_immediate), .power_reapplied(power_reapplied),
        .servo_on(servo_on), .abs_loss_alarm(abs_loss_alarm), .feedback_up(feedback_up),
        .feedback_down(feedback_down), .command_position_r(command_position_r),
        .deviation_r(deviation_r), .motor_step_cw_r(motor_step_cw_r),
        .motor_step_ccw_r(motor_step_ccw_r), .command_up_r(command_up_r),
        .command_down_r(command_down_r), .active_mode_r(active_mode_r),
        .resolution_ppr_r(resolution_ppr_r), .resolution_valid_r(resolution_valid_r),
        .gear_warning_r(gear_warning_r), .gear_alarm_r(gear_alarm_r),
        .pulse_blocked_r(pulse_blocked_r));
    // ==========================================
    // Shared tasks
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (12) @(negedge clock);
    endtask
    task automatic boot(input logic [2:0] m, input logic sw, input logic [9:0] den, num,
                        input logic pcw, rel, pos);
        int n;
        u_osc.idle(pos);
        {pulse_input_mode, input_mode_switch, gear_denominator, gear_numerator} =
            {m, sw, den, num};
        {positive_is_clockwise, loss_release_immediate, rst_n} = {pcw, rel, 1'b0};
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        // Bounded wait for the gear division
        for (n = 0; n < 80 && resolution_valid_r !== 1'b1; n++) @(negedge clock);
        if (n == 80) begin
            cmp("valid_wait", 1, 0);
            summarize();
        end
        repeat (3) @(negedge clock);
        {cw_n, ccw_n} = 0;
        p0 = command_position_r;
    endtask
    task automatic power_pulse();
        power_reapplied = 1'b1;
        @(negedge clock);
        power_reapplied = 1'b0;
        repeat (30) @(negedge clock);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_mode(input logic [2:0] m, input logic sw);
        int k, mu;
        logic pos;
        k = (m == 0) ? sw : (m < 3) ? 0 : (m < 5) ? 1 : 2;
        // Quadrature ignores polarity; its cycle starts with both phases low
        pos = (m == 2 || m == 4 || m > 4);
        mu = (m == 6) ? 2 : (m == 7) ? 4 : 1;
        boot(m, sw, 10'h001, 10'h001, m[0], 1'b1, pos);
        cmp("mode", (m == 0) ? (sw ? 3 : 1) : m, active_mode_r);
        u_osc.send(k, pos, 1'b1, 3);
        settle();
        cmp("pos_fwd", p0 + 3 * mu, command_position_r);
        u_osc.send(k, pos, 1'b0, 2);
        settle();
        cmp("pos_rev", p0 + mu, command_position_r);
        cmp("cw", m[0] ? 3 * mu : 2 * mu, cw_n);
        cmp("ccw", m[0] ? 2 * mu : 3 * mu, ccw_n);
    endtask
    task automatic t_gear(input logic [9:0] den, num, input logic [16:0] res, input logic w);
        boot(3'h2, 1'b0, den, num, 1'b1, 1'b1, 1'b1);
        cmp("res", res, resolution_ppr_r);
        cmp("warn", w, gear_warning_r);
    endtask
    task automatic t_alarm();
        boot(3'h2, 1'b0, 10'h001, 10'h065, 1'b1, 1'b1, 1'b1);
        power_pulse();
        cmp("alarm", 1, gear_alarm_r);
        u_osc.send(0, 1'b1, 1'b1, 2);
        settle();
        cmp("pos_alarm", p0, command_position_r);
    endtask
    task automatic t_latch();
        boot(3'h2, 1'b0, 10'h001, 10'h001, 1'b1, 1'b1, 1'b1);
        pulse_input_mode = 3'h4;
        u_osc.send(0, 1'b1, 1'b1, 1);
        settle();
        cmp("pos_latch", p0 + 1, command_position_r);
        power_pulse();
        cmp("mode_new", 4, active_mode_r);
    endtask
    task automatic t_servo();
        boot(3'h2, 1'b0, 10'h001, 10'h001, 1'b1, 1'b1, 1'b1);
        servo_on = 1'b0;
        u_osc.send(0, 1'b1, 1'b1, 2);
        settle();
        cmp("pos_off", p0, command_position_r);
        cmp("dev_off", 0, deviation_r);
        servo_on = 1'b1;
        u_osc.send(0, 1'b1, 1'b1, 3);
        settle();
        cmp("dev_on", 3, deviation_r);
        feedback_up = 1'b1;
        @(negedge clock);
        feedback_up = 1'b0;
        @(negedge clock);
        feedback_down = 1'b1;
        @(negedge clock);
        feedback_down = 1'b0;
        feedback_up = 1'b1;
        @(negedge clock);
        feedback_up = 1'b0;
        repeat (2) @(negedge clock);
        cmp("dev_fb", 2, deviation_r);
    endtask
    task automatic t_loss(input logic rel);
        boot(3'h2, 1'b0, 10'h001, 10'h001, 1'b1, rel, 1'b1);
        abs_loss_alarm = 1'b1;
        repeat (4) @(negedge clock);
        abs_loss_alarm = 1'b0;
        repeat (3) @(negedge clock);
        cmp("blocked", !rel, pulse_blocked_r);
        u_osc.send(0, 1'b1, 1'b1, 1);
        settle();
        cmp("pos_loss", p0 + rel, command_position_r);
        position_request_in = 1'b1;
        repeat (8) @(negedge clock);
        position_request_in = 1'b0;
        cmp("unblocked", 0, pulse_blocked_r);
    endtask
    initial begin
        for (int m = 0; m < 8; m++) t_mode(m[2:0], 1'b0);
        t_mode(3'h0, 1'b1);
        t_gear(10'h001, 10'h001, 17'h003E8, 1'b0);
        t_gear(10'h064, 10'h024, 17'h00168, 1'b0);
        t_gear(10'h00A, 10'h001, 17'h00064, 1'b0);
        t_gear(10'h3E8, 10'h063, 17'h00063, 1'b1);
        t_gear(10'h001, 10'h064, 17'h186A0, 1'b0);
        t_gear(10'h001, 10'h065, 17'h18A88, 1'b1);
        t_gear(10'h001, 10'h000, 17'h00000, 1'b1);
        t_alarm();
        t_latch();
        t_servo();
        t_loss(1'b0);
        t_loss(1'b1);
        summarize();
    end
endmodule // pulse_command_position_input_tb_top
